// [rtl/rco_defines.svh]
`ifndef RCO_DEFINES_SVH
`define RCO_DEFINES_SVH

// apb byte addresses
`define RCO_ADDR_CLKGEN 12'h000
`define RCO_ADDR_REF_PRI 12'h004
`define RCO_ADDR_REF_SEC 12'h008
`define RCO_ADDR_REF_CFG 12'h00C
`define RCO_ADDR_STATUS 12'h010

// free_clock_gen_ctrl fields
`define RCO_CG_T1_SEL 0
`define RCO_CG_T1_EN 1
`define RCO_CG_E1_SEL 2
`define RCO_CG_E1_EN 3
`define RCO_CG_RESET 4'h0

// reference output control fields
`define RCO_REF_SRC_MSB 4
`define RCO_REF_RATE_E1 5
`define RCO_REF_EN 6
`define RCO_REF_RESET 7'h00

// ref_shared_config fields
`define RCO_CFG_RATE_MSB 2
`define RCO_CFG_FREE 3
`define RCO_CFG_BYPASS 4
`define RCO_CFG_HOLD 5
`define RCO_CFG_TAP 6
`define RCO_CFG_RESET 7'h10

// source select codes
`define RCO_NUM_CHAN 5'h09
`define RCO_SRC_EXT_LO 5'h1D

// nco increments: rate * 2^32 / 250 MHz
`define RCO_INC_8K 32'h0002_18DF
`define RCO_INC_64K 32'h0010_C6F8
`define RCO_INC_T1 32'h0194_C016
`define RCO_INC_E1 32'h0218_DEF4
`define RCO_INC_4M 32'h0431_BDE8
`define RCO_INC_8M 32'h0863_7BD0
`define RCO_INC_19M 32'h13E8_04B1
`define RCO_INC_32M 32'h218D_EF40

// missing external clock: more than 8 periods without an edge
`define RCO_CLK_PS 4000
`define RCO_T1_PERIOD_PS 647668
`define RCO_E1_PERIOD_PS 488281
`define RCO_EXT_LOSS_EDGES 8
`define RCO_EXT_LOSS_T1_CYC \
  ((`RCO_EXT_LOSS_EDGES * `RCO_T1_PERIOD_PS + `RCO_CLK_PS - 1) / `RCO_CLK_PS)
`define RCO_EXT_LOSS_E1_CYC \
  ((`RCO_EXT_LOSS_EDGES * `RCO_E1_PERIOD_PS + `RCO_CLK_PS - 1) / `RCO_CLK_PS)

// strap capture settles after the pin synchroniser
`define RCO_STRAP_WAIT 2'h3

`endif

// [rtl/rco_pkg.sv]
package rco_pkg;

  typedef enum logic [1:0] {
    rco_src_chan = 2'b00,
    rco_src_master = 2'b01,
    rco_src_ext = 2'b10
  } rco_src_t;

  typedef enum logic [2:0] {
    rco_rate_8k = 3'b000,
    rco_rate_64k = 3'b001,
    rco_rate_2m = 3'b010,
    rco_rate_4m = 3'b011,
    rco_rate_8m = 3'b100,
    rco_rate_19m = 3'b101,
    rco_rate_32m = 3'b110,
    rco_rate_rsvd = 3'b111
  } rco_rate_t;

endpackage

// [rtl/rco_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module rco_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// [rtl/rco_nco.sv]
`timescale 1ns/1ps
`default_nettype none
module rco_nco (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [31:0] incr,
  output logic clk_out
);
  logic [31:0] acc;

  // phase accumulator; msb is the derived clock, cycle jitter is one
  // system period since 250 MHz is no multiple of the line rates
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      acc <= 32'h0000_0000;
    end else begin
      acc <= acc + incr;
    end
  end

  assign clk_out = acc[31];
endmodule
`default_nettype wire

// [rtl/rco_top.sv]
// Function
// - all derived clocks come from the system master clock; strap rate latched
// - free-running outputs follow only the master clock, never line clocks
// - t1 free output: off is high-z, else 8 kHz or t1 rate
// - e1 free output: off is high-z, else 8 kHz or e1 rate
// - bit 6 of each reference control enables; disabled pin is high-z
// - reference source: recovered line clock, master clock, or external input
// - bits 4..0 pick one of nine recovered channel clocks by default
// - primary without synthesizer carries channel clock at t1 or e1 rate
// - secondary carries channel clock at its line rate, no synthesizer
// - shared config bit 6 taps recovered clock before or after attenuator
// - synthesizer bypassed after reset; bit 4 low enables it
// - enabled synthesizer produces rate chosen by bits 2..0
// - bypass 0 and free 1 give synthesizer rate locked to master
// - source codes 29..31 route the dedicated external clock input
// - source channel loss of signal with hold-high forces outputs high, except the primary in free-run mode
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rco_defines.svh"
module rco_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] master_rate_strap,
  input wire logic [8:0] rec_clk_direct,
  input wire logic [8:0] rec_clk_atten,
  input wire logic [8:0] chan_mode_e1,
  input wire logic [8:0] line_signal_loss,
  input wire logic ext_clock_in_primary,
  input wire logic ext_clock_in_secondary,
  output logic t1_free_run_out,
  output logic t1_free_run_oe_n,
  output logic e1_free_run_out,
  output logic e1_free_run_oe_n,
  output logic ref_out_primary,
  output logic ref_out_primary_oe_n,
  output logic ref_out_secondary,
  output logic ref_out_secondary_oe_n
);
  logic [3:0] free_clock_gen_ctrl;
  logic [6:0] ref_ctrl [2];
  logic [6:0] ref_shared_config;
  logic [3:0] strap_latched;
  logic [1:0] strap_cnt;
  logic [8:0] rec_direct_s;
  logic [8:0] rec_atten_s;
  logic [8:0] mode_s;
  logic [8:0] los_s;
  logic [1:0] ext_s;
  logic [3:0] strap_s;
  logic nco_8k;
  logic nco_t1;
  logic nco_e1;
  logic nco_syn;
  logic [31:0] syn_incr;
  logic syn_rsvd;
  logic [31:0] rd_val;
  logic addr_hit;
  logic wr_en;
  logic [1:0] ref_base;
  logic [1:0] ref_master;
  logic [1:0] chan_lost;
  logic [1:0] ext_lost;
  logic next_pri;
  logic next_sec;
  logic synth_en;
  logic free_mode;

  // every pin-side input crosses into clk_sys before use
  rco_sync #(.WIDTH(42)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in({rec_clk_direct, rec_clk_atten, chan_mode_e1,
               line_signal_loss, ext_clock_in_secondary,
               ext_clock_in_primary, master_rate_strap}),
    .sync_out({rec_direct_s, rec_atten_s, mode_s, los_s, ext_s, strap_s})
  );

  rco_nco u_nco_8k (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .incr(`RCO_INC_8K),
    .clk_out(nco_8k)
  );

  rco_nco u_nco_t1 (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .incr(`RCO_INC_T1),
    .clk_out(nco_t1)
  );

  rco_nco u_nco_e1 (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .incr(`RCO_INC_E1),
    .clk_out(nco_e1)
  );

  rco_nco u_nco_syn (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .incr(syn_incr),
    .clk_out(nco_syn)
  );

  always_comb begin
    syn_rsvd = 1'b0;
    case (rco_pkg::rco_rate_t'(ref_shared_config[`RCO_CFG_RATE_MSB:0]))
      rco_pkg::rco_rate_8k: syn_incr = `RCO_INC_8K;
      rco_pkg::rco_rate_64k: syn_incr = `RCO_INC_64K;
      rco_pkg::rco_rate_2m: syn_incr = `RCO_INC_E1;
      rco_pkg::rco_rate_4m: syn_incr = `RCO_INC_4M;
      rco_pkg::rco_rate_8m: syn_incr = `RCO_INC_8M;
      rco_pkg::rco_rate_19m: syn_incr = `RCO_INC_19M;
      rco_pkg::rco_rate_32m: syn_incr = `RCO_INC_32M;
      default: begin
        syn_incr = 32'h0000_0000;
        syn_rsvd = 1'b1;
      end
    endcase
  end

  // strap rate caught once the synchroniser has settled
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      strap_cnt <= 2'h0;
      strap_latched <= 4'h0;
    end else if (strap_cnt != `RCO_STRAP_WAIT) begin
      strap_cnt <= strap_cnt + 2'h1;
      strap_latched <= strap_s;
    end
  end

  // per reference output: source decode and loss detection
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ref
      logic [4:0] src;
      logic [3:0] idx;
      rco_pkg::rco_src_t kind;
      logic rate_e1;
      logic chan_clk;
      logic ext_d;
      logic [11:0] gap_cnt;
      logic [11:0] gap_lim;

      assign src = ref_ctrl[gi][`RCO_REF_SRC_MSB:0];
      assign idx = src[3:0];

      // channel codes, external codes, others use master
      always_comb begin
        if (src < `RCO_NUM_CHAN) begin
          kind = rco_pkg::rco_src_chan;
        end else if (src >= `RCO_SRC_EXT_LO) begin
          kind = rco_pkg::rco_src_ext;
        end else begin
          kind = rco_pkg::rco_src_master;
        end
      end

      // tap before or after the attenuator
      always_comb begin
        if (kind == rco_pkg::rco_src_chan) begin
          chan_clk = ref_shared_config[`RCO_CFG_TAP] ?
                     rec_direct_s[idx] : rec_atten_s[idx];
        end else begin
          chan_clk = 1'b0;
        end
      end

      assign rate_e1 = (kind == rco_pkg::rco_src_chan) ?
                       mode_s[idx] : ref_ctrl[gi][`RCO_REF_RATE_E1];
      assign ref_master[gi] = rate_e1 ? nco_e1 : nco_t1;
      assign chan_lost[gi] = (kind == rco_pkg::rco_src_chan) & los_s[idx];

      always_comb begin
        case (kind)
          rco_pkg::rco_src_chan: ref_base[gi] = chan_clk;
          rco_pkg::rco_src_ext: ref_base[gi] = ext_s[gi];
          default: ref_base[gi] = ref_master[gi];
        endcase
      end

      // missing external clock: no edge for more than 8 of its periods
      assign gap_lim = ref_ctrl[gi][`RCO_REF_RATE_E1] ?
                       12'(`RCO_EXT_LOSS_E1_CYC) :
                       12'(`RCO_EXT_LOSS_T1_CYC);

      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          ext_d <= 1'b0;
          gap_cnt <= 12'h000;
        end else begin
          ext_d <= ext_s[gi];
          if (ext_d != ext_s[gi]) begin
            gap_cnt <= 12'h000;
          end else if (gap_cnt <= gap_lim) begin
            gap_cnt <= gap_cnt + 12'h001;
          end
        end
      end

      assign ext_lost[gi] = (kind == rco_pkg::rco_src_ext) &
                            (gap_cnt > gap_lim);
    end
  endgenerate

  // bypass bit low enables the synthesizer
  assign synth_en = ~ref_shared_config[`RCO_CFG_BYPASS];
  // free-run: synthesizer rate locked to master clock
  assign free_mode = synth_en & ref_shared_config[`RCO_CFG_FREE];

  always_comb begin
    if (free_mode) begin
      // reserved free-run codes hold the pin low
      next_pri = (ref_shared_config[`RCO_CFG_RATE_MSB:0] == 3'b000 ||
                  ref_shared_config[`RCO_CFG_RATE_MSB:0] == 3'b011 ||
                  syn_rsvd) ? 1'b0 : nco_syn;
    end else if (ext_lost[0]) begin
      next_pri = 1'b1;
    end else if (chan_lost[0]) begin
      if (ref_shared_config[`RCO_CFG_HOLD]) begin
        next_pri = 1'b1;
      end else begin
        next_pri = synth_en ? nco_syn : ref_master[0];
      end
    end else if (synth_en) begin
      next_pri = syn_rsvd ? 1'b0 : nco_syn;
    end else begin
      next_pri = ref_base[0];
    end
  end

  // secondary: hold high or fall back to master at same rate
  always_comb begin
    if (chan_lost[1] | ext_lost[1]) begin
      next_sec = ref_shared_config[`RCO_CFG_HOLD] ? 1'b1 : ref_master[1];
    end else begin
      next_sec = ref_base[1];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ref_out_primary <= 1'b0;
      ref_out_primary_oe_n <= 1'b1;
      ref_out_secondary <= 1'b0;
      ref_out_secondary_oe_n <= 1'b1;
    end else begin
      ref_out_primary <= ref_ctrl[0][`RCO_REF_EN] & next_pri;
      ref_out_primary_oe_n <= ~ref_ctrl[0][`RCO_REF_EN];
      ref_out_secondary <= ref_ctrl[1][`RCO_REF_EN] & next_sec;
      ref_out_secondary_oe_n <= ~ref_ctrl[1][`RCO_REF_EN];
    end
  end

  // free outputs from master-derived clocks only
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      t1_free_run_out <= 1'b0;
      t1_free_run_oe_n <= 1'b1;
      e1_free_run_out <= 1'b0;
      e1_free_run_oe_n <= 1'b1;
    end else begin
      t1_free_run_out <= free_clock_gen_ctrl[`RCO_CG_T1_EN] &
        (free_clock_gen_ctrl[`RCO_CG_T1_SEL] ? nco_t1 : nco_8k);
      t1_free_run_oe_n <= ~free_clock_gen_ctrl[`RCO_CG_T1_EN];
      e1_free_run_out <= free_clock_gen_ctrl[`RCO_CG_E1_EN] &
        (free_clock_gen_ctrl[`RCO_CG_E1_SEL] ? nco_e1 : nco_8k);
      e1_free_run_oe_n <= ~free_clock_gen_ctrl[`RCO_CG_E1_EN];
    end
  end

  // apb read decode; misaligned or unknown addresses are errors
  always_comb begin
    addr_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `RCO_ADDR_CLKGEN: rd_val = {28'h0, free_clock_gen_ctrl};
      `RCO_ADDR_REF_PRI: rd_val = {25'h0, ref_ctrl[0]};
      `RCO_ADDR_REF_SEC: rd_val = {25'h0, ref_ctrl[1]};
      `RCO_ADDR_REF_CFG: rd_val = {25'h0, ref_shared_config};
      `RCO_ADDR_STATUS: rd_val = {22'h0, ref_out_secondary,
                                  ref_out_primary, chan_lost[1],
                                  chan_lost[0], ext_lost[1], ext_lost[0],
                                  strap_latched};
      default: addr_hit = 1'b0;
    endcase
  end

  // no wait state: answer prepared in setup, taken in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= ~addr_hit;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  assign wr_en = psel & penable & pready & pwrite & addr_hit;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      free_clock_gen_ctrl <= `RCO_CG_RESET;
      ref_ctrl[0] <= `RCO_REF_RESET;
      ref_ctrl[1] <= `RCO_REF_RESET;
      ref_shared_config <= `RCO_CFG_RESET;
    end else if (wr_en) begin
      case (paddr)
        `RCO_ADDR_CLKGEN: free_clock_gen_ctrl <= pwdata[3:0];
        `RCO_ADDR_REF_PRI: ref_ctrl[0] <= pwdata[6:0];
        `RCO_ADDR_REF_SEC: ref_ctrl[1] <= pwdata[6:0];
        `RCO_ADDR_REF_CFG: ref_shared_config <= pwdata[6:0];
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// [test/rco_top_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module rco_top_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic t1_free_run_oe_n,
  input wire logic e1_free_run_oe_n,
  input wire logic ref_out_primary,
  input wire logic ref_out_primary_oe_n,
  input wire logic ref_out_secondary_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic setup;
  logic wr_acc;
  logic bad;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;
  assign bad = paddr[1:0] != 2'h0 || paddr > 12'h010;
  // register lands at the access edge, pin enable one edge later
  property p_oe(logic hit, logic bitv, logic oe);
    hit |-> ##2 (oe == !$past(bitv, 2));
  endproperty
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_bad_addr: assert property (setup && bad |=> pready && pslverr)
    else $error("bad address not refused");
  a_err_good_addr: assert property (setup && !bad |=> !pslverr)
    else $error("good address refused");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  a_t1_oe_follow:
    assert property (p_oe(wr_acc && paddr == 12'h000, pwdata[1],
      t1_free_run_oe_n)) else $error("t1 enable not applied");
  a_e1_oe_follow:
    assert property (p_oe(wr_acc && paddr == 12'h000, pwdata[3],
      e1_free_run_oe_n)) else $error("e1 enable not applied");
  a_pri_oe_follow:
    assert property (p_oe(wr_acc && paddr == 12'h004, pwdata[6],
      ref_out_primary_oe_n)) else $error("primary enable not applied");
  a_sec_oe_follow:
    assert property (p_oe(wr_acc && paddr == 12'h008, pwdata[6],
      ref_out_secondary_oe_n)) else $error("secondary enable not applied");
  a_pri_off_low:
    assert property (ref_out_primary_oe_n |-> !ref_out_primary)
    else $error("disabled primary not low");
  c_pri_write: cover property (wr_acc && paddr == 12'h004);
  c_refused: cover property (pslverr);
  c_pri_driven: cover property (!ref_out_primary_oe_n && ref_out_primary);
endmodule
bind rco_top rco_top_chk rco_top_chk_inst (.clk_sys, .nrst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .t1_free_run_oe_n, .e1_free_run_oe_n, .ref_out_primary,
  .ref_out_primary_oe_n, .ref_out_secondary_oe_n);
`default_nettype wire

// [test/rco_board_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rco_board_model (
  input wire logic clk_sys,
  input wire logic atten_stall,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  output logic [8:0] rec_clk_direct,
  output logic [8:0] rec_clk_atten,
  output logic ext_clk_t1,
  output logic ext_clk_e1,
  output logic [63:0] edge_cnt
);
  logic [3:0] prev;
  initial begin
    rec_clk_direct = 9'h000;
    rec_clk_atten = 9'h000;
    ext_clk_t1 = 1'b0;
    ext_clk_e1 = 1'b0;
    edge_cnt = 64'h0;
    prev = 4'hF;
  end
  // odd channels run at e1 rate, even ones at t1 rate
  for (genvar i = 0; i < 9; i++) begin : g_ch
    always #((i % 2) ? 244.141 : 323.834)
      rec_clk_direct[i] = ~rec_clk_direct[i];
  end
  always #323.834 ext_clk_t1 = ~ext_clk_t1;
  always #244.141 ext_clk_e1 = ~ext_clk_e1;
  // a stalled attenuator freezes its clock rather than passing the line
  always @* if (!atten_stall) rec_clk_atten = rec_clk_direct;
  // only driven pins count; a released pin never yields an edge
  always @(posedge clk_sys) begin
    for (int k = 0; k < 4; k++) begin
      if (!pin_oe_n[k] && pin_out[k] === 1'b1 && !prev[k])
        edge_cnt[16*k +: 16] <= edge_cnt[16*k +: 16] + 16'h1;
      prev[k] <= pin_oe_n[k] ? 1'b1 : pin_out[k];
    end
  end
endmodule
`default_nettype wire

// [test/tb_reference_clock_output_select.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_reference_clock_output_select;
  localparam logic [3:0] STRAP = 4'h5;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [8:0] line_signal_loss = 9'h000;
  logic atten_stall = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [8:0] rec_d;
  logic [8:0] rec_a;
  logic ext_t1;
  logic ext_e1;
  logic [3:0] pin_out;
  logic [3:0] pin_oe_n;
  logic [63:0] edge_cnt;
  logic [15:0] cnt [4];
  real rates [7] = '{0.008, 0.064, 2.048, 4.096, 8.192, 19.44, 32.768};
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #2 clk_sys = ~clk_sys;
  rco_top rco_top_inst (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .master_rate_strap(STRAP),
    .rec_clk_direct(rec_d), .rec_clk_atten(rec_a), .chan_mode_e1(9'h0AA),
    .line_signal_loss, .ext_clock_in_primary(ext_t1),
    .ext_clock_in_secondary(ext_e1), .t1_free_run_out(pin_out[0]),
    .t1_free_run_oe_n(pin_oe_n[0]), .e1_free_run_out(pin_out[1]),
    .e1_free_run_oe_n(pin_oe_n[1]), .ref_out_primary(pin_out[2]),
    .ref_out_primary_oe_n(pin_oe_n[2]), .ref_out_secondary(pin_out[3]),
    .ref_out_secondary_oe_n(pin_oe_n[3]));
  rco_board_model rco_board_model_inst (.clk_sys, .atten_stall, .pin_out,
    .pin_oe_n, .rec_clk_direct(rec_d), .rec_clk_atten(rec_a),
    .ext_clk_t1(ext_t1), .ext_clk_e1(ext_e1), .edge_cnt);
  task close_out();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task fail(input string m);
    num_errors++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task chk32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
  endtask
  // nco edges jitter by one period, so allow one edge either way
  task chk_cnt(input logic [15:0] got, input real mhz);
    int e;
    e = $rtoi(mhz * 10.0 + 0.5);
    samples_checked++;
    if ((got + 1 >= e && got <= e + 1) !== 1'b1)
      fail($sformatf("edges %0d expected %0d", got, e));
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) fail("no ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    xfer(1'b1, a, d, rd, er);
    chk32({31'h0, er}, 32'h0);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
      input logic [31:0] mask, input logic exp_er);
    logic [31:0] rd;
    logic er;
    xfer(1'b0, a, 32'h0, rd, er);
    chk32(rd & mask, exp);
    chk32({31'h0, er}, {31'h0, exp_er});
  endtask
  task measure();
    logic [63:0] s;
    repeat (40) @(posedge clk_sys);
    s = edge_cnt;
    repeat (2500) @(posedge clk_sys);
    for (int k = 0; k < 4; k++) cnt[k] = edge_cnt[16*k +: 16] - s[16*k +: 16];
  endtask
  task end_test(input string name);
    $display("test %s finished, errors so far %0d", name, num_errors);
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fail("timeout");
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk32({28'h0, pin_oe_n}, 32'hF);
    rd_chk(12'h000, 32'h0, 32'hFFFFFFFF, 1'b0);
    rd_chk(12'h004, 32'h0, 32'hFFFFFFFF, 1'b0);
    rd_chk(12'h008, 32'h0, 32'hFFFFFFFF, 1'b0);
    rd_chk(12'h00C, 32'h10, 32'hFFFFFFFF, 1'b0);
    rd_chk(12'h010, {28'h0, STRAP}, 32'hF, 1'b0);
    rd_chk(12'h014, 32'h0, 32'hFFFFFFFF, 1'b1);
    rd_chk(12'h002, 32'h0, 32'hFFFFFFFF, 1'b1);
    end_test("reset");
    wr(12'h000, 32'hF);
    wr(12'h004, 32'h41);
    wr(12'h008, 32'h40);
    measure();
    chk_cnt(cnt[0], 1.544);
    chk_cnt(cnt[1], 2.048);
    chk_cnt(cnt[2], 2.048);
    chk_cnt(cnt[3], 1.544);
    end_test("recovery");
    wr(12'h000, 32'hA);
    wr(12'h008, 32'h69);
    for (int c = 29; c < 32; c++) begin
      wr(12'h004, 32'h40 | c);
      measure();
      chk_cnt(cnt[2], 1.544);
    end
    chk_cnt(cnt[0], 0.008);
    chk_cnt(cnt[1], 0.008);
    chk_cnt(cnt[3], 2.048);
    end_test("sources");
    wr(12'h000, 32'h5);
    wr(12'h004, 32'h01);
    wr(12'h008, 32'h3F);
    measure();
    chk32({28'h0, pin_oe_n}, 32'hF);
    end_test("disabled");
    wr(12'h004, 32'h41);
    atten_stall <= 1'b1;
    measure();
    chk32({16'h0, cnt[2]}, 32'h0);
    wr(12'h00C, 32'h50);
    measure();
    chk_cnt(cnt[2], 2.048);
    atten_stall <= 1'b0;
    end_test("tap");
    wr(12'h004, 32'h40);
    for (int i = 0; i < 7; i++) begin
      wr(12'h00C, i);
      measure();
      chk_cnt(cnt[2], rates[i]);
    end
    wr(12'h00C, 32'h7);
    measure();
    chk32({16'h0, cnt[2]}, 32'h0);
    wr(12'h00C, 32'hA);
    measure();
    chk_cnt(cnt[2], 2.048);
    end_test("synth");
    wr(12'h00C, 32'h30);
    wr(12'h004, 32'h41);
    wr(12'h008, 32'h41);
    line_signal_loss <= 9'h002;
    measure();
    chk32({16'h0, cnt[2] | cnt[3]}, 32'h0);
    chk32({30'h0, pin_out[3:2]}, 32'h3);
    rd_chk(12'h010, 32'h3C5, 32'h3FF, 1'b0);
    wr(12'h00C, 32'h10);
    measure();
    chk_cnt(cnt[2], 2.048);
    chk_cnt(cnt[3], 2.048);
    line_signal_loss <= 9'h000;
    end_test("hold");
    close_out();
  end
endmodule
`default_nettype wire
